//--- hdl/arfg_cfg.svh
// Register addresses, field positions and reset values of the result and gain block.
`ifndef ARFG_CFG_SVH
`define ARFG_CFG_SVH
// ----------------------------------------------------------------
// Register addresses on the special function register bus
// ----------------------------------------------------------------
`define ARFG_ADDR_RES_HI 8'hbe
`define ARFG_ADDR_RES_LO 8'hbd
`define ARFG_ADDR_CFG    8'hbc
`define ARFG_ADDR_CTL    8'hf8
// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define ARFG_CFG_RST     8'hf8
`define ARFG_CTL_RST     8'h00
`define ARFG_RES_RST     16'h0000
`define ARFG_GAIN_EN_BIT 0
`define ARFG_RPT_LSB     1
`define ARFG_LJST_BIT    2
// ----------------------------------------------------------------
// Indirect gain addresses, reset values and scaling
// ----------------------------------------------------------------
`define ARFG_GADDR_HI    8'h04
`define ARFG_GADDR_LO    8'h07
`define ARFG_GADDR_EXTRA 8'h08
`define ARFG_GAIN_HI_RST 8'hfc
`define ARFG_GAIN_LO_RST 4'h0
`define ARFG_EXTRA_RST   1'b1
`define ARFG_EXTRA_UNIT  13'h0040
`endif

//--- hdl/arfg_pkg.sv
// Types shared by the result formatting and gain access block.
package arfg_pkg;
  // Repeat count codes: 1, 4, 8 or 16 accumulated conversions.
  typedef enum logic [1:0] {
    ARFG_RPT_1  = 2'h0,
    ARFG_RPT_4  = 2'h1,
    ARFG_RPT_8  = 2'h2,
    ARFG_RPT_16 = 2'h3
  } arfg_rpt_t;
  // Accumulator states, one-hot.
  typedef enum logic [1:0] {
    ARFG_ST_IDLE = 2'h1,
    ARFG_ST_ACC  = 2'h2
  } arfg_acc_st_t;
endpackage

//--- hdl/arfg_accum.sv
// Sample accumulator that sums a series of conversions.
`timescale 1ns/1ps
`default_nettype none
module arfg_accum
  import arfg_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int SUM_W    = 16
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire arfg_rpt_t           rpt_sel,
  input  wire logic                restart,
  output logic      [SUM_W-1:0]    sum_q,
  output logic                     done_q
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Sixteen samples need four bits of headroom above the sample width.
  if (SUM_W < SAMPLE_W + 4) begin : g_chk
    $error("arfg_accum: SUM_W too narrow for sixteen samples");
  end

  arfg_acc_st_t     st_q, st_d;      // Series in progress or not.
  logic [3:0]       cnt_q, cnt_d;    // Samples already taken in the series.
  logic [SUM_W-1:0] acc_q, acc_d;    // Running partial sum.
  logic [SUM_W-1:0] sum_d;           // Next published sum.
  logic             done_d;          // Next completion pulse.
  logic [3:0]       last_idx;        // Index of the final sample.
  logic [SUM_W-1:0] acc_in;          // Partial sum feeding the adder.
  logic [SUM_W-1:0] sum_next;        // Partial sum plus the new sample.

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Each sample is added unsigned; only the final one publishes.
  always_comb begin
    case (rpt_sel)
      ARFG_RPT_4:  last_idx = 4'h3;
      ARFG_RPT_8:  last_idx = 4'h7;
      ARFG_RPT_16: last_idx = 4'hf;
      default:     last_idx = 4'h0;
    endcase
    case (st_q)
      ARFG_ST_ACC: acc_in = acc_q;
      default:     acc_in = '0;
    endcase
    sum_next = acc_in + SUM_W'(sample);
    st_d   = st_q;
    cnt_d  = cnt_q;
    acc_d  = acc_q;
    sum_d  = sum_q;
    done_d = 1'b0;
    if (restart) begin
      // A new repeat setting abandons any partial series.
      st_d  = ARFG_ST_IDLE;
      cnt_d = 4'h0;
      acc_d = '0;
    end else if (sample_valid) begin
      if (cnt_q == last_idx) begin
        // Final sample: publish the whole sum at once.
        sum_d  = sum_next;
        done_d = 1'b1;
        st_d   = ARFG_ST_IDLE;
        cnt_d  = 4'h0;
      end else begin
        acc_d = sum_next;
        cnt_d = cnt_q + 4'h1;
        st_d  = ARFG_ST_ACC;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ARFG_ST_IDLE;
      cnt_q  <= 4'h0;
      acc_q  <= '0;
      sum_q  <= '0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      acc_q  <= acc_d;
      sum_q  <= sum_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_single;
    sample_valid && !restart && rpt_sel == ARFG_RPT_1;
  endsequence
  sequence s_four;
    (sample_valid && !restart && rpt_sel == ARFG_RPT_4 && !done_q)[*1] ##0 cnt_q == 4'h3;
  endsequence

  single_done_a: assert property (s_single |=> done_q && sum_q == SUM_W'($past(sample)))
    else $error("single conversion did not publish its sample");
  four_done_a: assert property (s_four |=> done_q && cnt_q == 4'h0)
    else $error("fourth sample did not close the series");
  no_early_a: assert property (done_q |-> $past(sample_valid) && $past(cnt_q) == $past(last_idx))
    else $error("result published before the final sample");
  sum_add_a: assert property (sample_valid && !restart && st_q == ARFG_ST_ACC
                              |=> (done_q ? sum_q : acc_q) == $past(acc_q) + SUM_W'($past(sample)))
    else $error("accumulated sum is not the plain binary sum");
endmodule
`default_nettype wire

//--- hdl/arfg_top.sv
// Result formatting, accumulation and indirect gain access for the converter.
`timescale 1ns/1ps
`default_nettype none
`include "arfg_cfg.svh"
// Summary of operation
// - Single conversion gives 12-bit result each time.
// - Justify bit picks right or left placement for single conversions.
// - Unused result bits always read zero.
// - Repeat series updates result after last sample.
// - Accumulated result is plain binary sample sum.
// - Gain is 13 bits in three registers.
// - Extra bit adds one sixty-fourth gain.
// - Reset gives 0xFC, 0x00, extra one.
// - Gain equals word/4096 plus extra/64.
// - Enabled: high byte addresses, low byte loads.
// - Gain registers are write-only, never read.
// - Gain addresses 0x04, 0x07, 0x08.
// - Repeat code selects 1, 4, 8, 16.
module arfg_top
  import arfg_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int SUM_W    = 16
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample,
  output logic      [7:0]          sfr_rdata_q,
  output logic      [7:0]          config_q,
  output logic      [7:0]          control_q,
  output logic      [7:0]          gain_word_high_q,
  output logic      [3:0]          gain_word_low_q,
  output logic                     extra_gain_bit_q,
  output logic      [12:0]         gain_scaled_q,
  output logic                     result_update_q
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The result registers are two bytes and hold a 12-bit sample, right- or left-justified, or a 16-bit sum.
  if (SAMPLE_W != 12 || SUM_W != 16) begin : g_chk
    $error("arfg_top: result format needs SAMPLE_W 12 and SUM_W 16");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]      result_q, result_d;    // Formatted result word.
  logic [7:0]       gaddr_q, gaddr_d;      // Indirect gain address latch.
  logic [7:0]       config_d;              // Next configuration byte.
  logic [7:0]       control_d;             // Next control byte.
  logic [7:0]       gain_hi_d;             // Next upper gain byte.
  logic [3:0]       gain_lo_d;             // Next lower gain nibble.
  logic             extra_d;               // Next extra-gain bit.
  logic [12:0]      scaled_d;              // Next effective gain numerator.
  logic [7:0]       rdata_d;               // Next read data.
  logic             wr_cfg;                // Configuration write strobe.
  logic             wr_hi;                 // Result high byte write strobe.
  logic             wr_lo;                 // Result low byte write strobe.
  logic             gain_en;               // Gain access enable.
  logic             ljst;                  // Justify select.
  arfg_rpt_t        rpt_sel;               // Repeat count select.
  logic [SUM_W-1:0] acc_sum;               // Published sum from the accumulator.
  logic             acc_done;              // Series complete pulse.

  assign wr_cfg  = sfr_wr && sfr_addr == `ARFG_ADDR_CFG;
  assign wr_hi   = sfr_wr && sfr_addr == `ARFG_ADDR_RES_HI;
  assign wr_lo   = sfr_wr && sfr_addr == `ARFG_ADDR_RES_LO;
  assign gain_en = config_q[`ARFG_GAIN_EN_BIT];
  assign ljst    = control_q[`ARFG_LJST_BIT];
  assign rpt_sel = arfg_rpt_t'(config_q[`ARFG_RPT_LSB +: 2]);

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // A write to the configuration register restarts any partial series.
  arfg_accum #(
    .SAMPLE_W (SAMPLE_W),
    .SUM_W    (SUM_W)
  ) u_accum (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .sample_valid (sample_valid),
    .sample       (sample),
    .rpt_sel      (rpt_sel),
    .restart      (wr_cfg),
    .sum_q        (acc_sum),
    .done_q       (acc_done)
  );

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  // Left placement applies only to single conversions; a repeat series is
  // always shown right-justified, so a software slip cannot overflow the word.
  always_comb begin
    result_d = result_q;
    if (acc_done) begin
      if (ljst && rpt_sel == ARFG_RPT_1) begin
        result_d = {acc_sum[SAMPLE_W-1:0], 4'h0};
      end else begin
        result_d = acc_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers and indirect gain access
  // ----------------------------------------------------------------
  // The gain registers change only through the indirect path while enabled.
  always_comb begin
    config_d  = config_q;
    control_d = control_q;
    gaddr_d   = gaddr_q;
    gain_hi_d = gain_word_high_q;
    gain_lo_d = gain_word_low_q;
    extra_d   = extra_gain_bit_q;
    if (wr_cfg) begin
      config_d = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `ARFG_ADDR_CTL) begin
      control_d = sfr_wdata;
    end
    if (gain_en) begin
      if (wr_hi) begin
        gaddr_d = sfr_wdata;
      end
      if (wr_lo) begin
        case (gaddr_q)
          `ARFG_GADDR_HI:    gain_hi_d = sfr_wdata;
          `ARFG_GADDR_LO:    gain_lo_d = sfr_wdata[7:4];
          `ARFG_GADDR_EXTRA: extra_d = sfr_wdata[0];
          default:           gain_hi_d = gain_word_high_q;
        endcase
      end
    end
    // Effective gain in units of 1/4096: word plus 64 when the extra bit is set.
    scaled_d = {1'b0, gain_hi_d, gain_lo_d} + (extra_d ? `ARFG_EXTRA_UNIT : 13'h0000);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Result bytes always return the result, so gain values never leak out.
  always_comb begin
    rdata_d = sfr_rdata_q;
    if (sfr_rd) begin
      case (sfr_addr)
        `ARFG_ADDR_RES_HI: rdata_d = result_q[15:8];
        `ARFG_ADDR_RES_LO: rdata_d = result_q[7:0];
        `ARFG_ADDR_CFG:    rdata_d = config_q;
        `ARFG_ADDR_CTL:    rdata_d = control_q;
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Gain defaults give unity gain after reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q         <= `ARFG_RES_RST;
      gaddr_q          <= 8'h00;
      config_q         <= `ARFG_CFG_RST;
      control_q        <= `ARFG_CTL_RST;
      gain_word_high_q <= `ARFG_GAIN_HI_RST;
      gain_word_low_q  <= `ARFG_GAIN_LO_RST;
      extra_gain_bit_q <= `ARFG_EXTRA_RST;
      gain_scaled_q    <= 13'h1000;
      sfr_rdata_q      <= 8'h00;
      result_update_q  <= 1'b0;
    end else begin
      result_q         <= result_d;
      gaddr_q          <= gaddr_d;
      config_q         <= config_d;
      control_q        <= control_d;
      gain_word_high_q <= gain_hi_d;
      gain_word_low_q  <= gain_lo_d;
      extra_gain_bit_q <= extra_d;
      gain_scaled_q    <= scaled_d;
      sfr_rdata_q      <= rdata_d;
      result_update_q  <= acc_done;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_gain_load;
    gain_en && wr_hi && sfr_wdata == `ARFG_GADDR_HI ##1 gain_en && wr_lo;
  endsequence

  left_place_a: assert property (acc_done && ljst && rpt_sel == ARFG_RPT_1
                                 |=> result_q[3:0] == 4'h0 && result_q[15:4] == $past(acc_sum[11:0]))
    else $error("left-justified result misplaced");
  right_zero_a: assert property (acc_done && !ljst && rpt_sel == ARFG_RPT_1
                                 |=> result_q[15:12] == 4'h0)
    else $error("unused high result bits not zero");
  update_only_a: assert property (!acc_done |=> $stable(result_q))
    else $error("result changed without a completed series");
  gain_load_a: assert property (s_gain_load |=> gain_word_high_q == $past(sfr_wdata))
    else $error("indirect load of upper gain byte failed");
  gain_locked_a: assert property (!gain_en |=> $stable({gain_word_high_q, gain_word_low_q,
                                                       extra_gain_bit_q}))
    else $error("gain changed with access disabled");
  read_result_a: assert property (sfr_rd && sfr_addr == `ARFG_ADDR_RES_LO
                                  |=> sfr_rdata_q == $past(result_q[7:0]))
    else $error("low result byte read returned something else");
  gain_scale_a: assert property (##1 gain_scaled_q == {1'b0, gain_word_high_q, gain_word_low_q}
                                 + (extra_gain_bit_q ? 13'h0040 : 13'h0000))
    else $error("effective gain does not match the gain registers");
  extra_addr_a: assert property (gain_en && wr_lo && gaddr_q == `ARFG_GADDR_EXTRA
                                 |=> extra_gain_bit_q == $past(sfr_wdata[0])
                                 && $stable(gain_word_high_q))
    else $error("extra gain address did not load the extra bit alone");
endmodule
`default_nettype wire

//--- verif/test_adc_result_format_gain_access.sv
// Self-checking testbench for the result formatting and gain access block.
`timescale 1ns/1ps
`default_nettype none
`include "arfg_cfg.svh"
module test_adc_result_format_gain_access;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk;           // System clock, 40 ns period.
  logic        rst_n;             // Asynchronous reset, active low.
  logic [7:0]  sfr_addr;          // Register address.
  logic [7:0]  sfr_wdata;         // Register write data.
  logic        sfr_wr;            // Write strobe.
  logic        sfr_rd;            // Read strobe.
  logic        sample_valid;      // Conversion done pulse.
  logic [11:0] sample;            // Conversion code.
  logic [7:0]  sfr_rdata_q;       // Read data.
  logic [7:0]  config_q;          // Configuration byte.
  logic [7:0]  control_q;         // Control byte.
  logic [7:0]  gain_word_high_q;  // Upper gain byte.
  logic [3:0]  gain_word_low_q;   // Lower gain nibble.
  logic        extra_gain_bit_q;  // Extra gain bit.
  logic [12:0] gain_scaled_q;     // Effective gain in 1/4096 units.
  logic        result_update_q;   // Result refreshed pulse.
  int          err_count;         // Mismatches seen.
  int          n_tests;           // Comparisons made.
  logic [15:0] res_a;             // Result before a gain sequence.
  logic [15:0] res_b;             // Result after a gain sequence.
  logic [7:0]  byte_v;            // Scratch read byte.

  // ----------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------
  arfg_top #(.SAMPLE_W(12), .SUM_W(16)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sample_valid(sample_valid), .sample(sample),
    .sfr_rdata_q(sfr_rdata_q), .config_q(config_q), .control_q(control_q),
    .gain_word_high_q(gain_word_high_q), .gain_word_low_q(gain_word_low_q),
    .extra_gain_bit_q(extra_gain_bit_q), .gain_scaled_q(gain_scaled_q),
    .result_update_q(result_update_q)
  );

  // The clock toggles every half period of 20 ns.
  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("TB counts: %0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Issues one write strobe, held for exactly one sampling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #2;
    sfr_wr = 1'b0;
  endtask

  // Issues one read strobe and takes the data once it has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #2;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge ref_clk);
    #2;
    sfr_rd = 1'b0;
    @(posedge ref_clk);
    #2;
    d = sfr_rdata_q;
  endtask

  // Reads the result word as high byte then low byte.
  task automatic rd_res(output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    rd(`ARFG_ADDR_RES_HI, h);
    rd(`ARFG_ADDR_RES_LO, l);
    r = {h, l};
  endtask

  // Writes one gain register through the address and data bytes.
  // The strobe stays up, so the address and data writes land on back-to-back edges.
  task automatic gain_set(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #2;
    sfr_addr = `ARFG_ADDR_RES_HI;
    sfr_wdata = a;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #2;
    sfr_addr = `ARFG_ADDR_RES_LO;
    sfr_wdata = v;
    @(posedge ref_clk);
    #2;
    sfr_wr = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Checks the register and gain values right after reset.
  task automatic t_reset();
    chk(16'(config_q), 16'h00f8, "config reset");
    chk(16'(control_q), 16'h0000, "control reset");
    chk(16'(gain_word_high_q), 16'h00fc, "gain high reset");
    chk(16'(gain_word_low_q), 16'h0000, "gain low reset");
    chk(16'(extra_gain_bit_q), 16'h0001, "extra bit reset");
    chk(16'(gain_scaled_q), 16'h1000, "unity gain");
  endtask

  // Runs one series of samples and checks the timing and value of the result.
  task automatic series(input logic [1:0] code, input int n, input logic lj,
                        input logic [11:0] base, input logic [11:0] step);
    logic [15:0] exp;
    logic [15:0] got;
    int          w;
    exp = 16'h0000;
    wr(`ARFG_ADDR_CFG, {5'h1f, code, 1'b0});
    wr(`ARFG_ADDR_CTL, {5'h00, lj, 2'h0});
    for (int i = 0; i < n; i++) begin
      sample = base - (step * 12'(i));
      exp = exp + {4'h0, sample};
      sample_valid = 1'b1;
      @(posedge ref_clk);
      #2;
      // No refresh is allowed before the final sample of the series.
      if (i < n - 1) chk(16'(result_update_q), 16'h0000, "early update");
    end
    sample_valid = 1'b0;
    // Left placement is only used with a single sample, so the sum is that sample.
    if (lj) exp = {exp[11:0], 4'h0};
    w = 0;
    while (result_update_q !== 1'b1 && w < 4) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    chk(16'(w), 16'h0001, "update delay");
    rd_res(got);
    chk(got, exp, "result word");
  endtask

  // Programs the gain through indirect access and checks every field.
  task automatic t_gain();
    rd_res(res_a);
    wr(`ARFG_ADDR_CFG, 8'hf9);
    gain_set(`ARFG_GADDR_HI, 8'h6c);
    gain_set(`ARFG_GADDR_LO, 8'ha0);
    gain_set(`ARFG_GADDR_EXTRA, 8'h01);
    // While access is enabled, the low result byte still reads the result.
    rd(`ARFG_ADDR_RES_LO, byte_v);
    chk(16'(byte_v), {8'h00, res_a[7:0]}, "gain hidden while enabled");
    wr(`ARFG_ADDR_CFG, 8'hf8);
    @(posedge ref_clk);
    #2;
    chk(16'(gain_word_high_q), 16'h006c, "gain high");
    chk(16'(gain_word_low_q), 16'h000a, "gain low");
    chk(16'(extra_gain_bit_q), 16'h0001, "extra bit");
    chk(16'(gain_scaled_q), 16'h070a, "gain with extra");
    rd_res(res_b);
    chk(res_b, res_a, "result kept by gain writes");
    wr(`ARFG_ADDR_CFG, 8'hf9);
    gain_set(`ARFG_GADDR_EXTRA, 8'h00);
    wr(`ARFG_ADDR_CFG, 8'hf8);
    @(posedge ref_clk);
    #2;
    chk(16'(gain_scaled_q), 16'h06ca, "gain without extra");
    rd(`ARFG_GADDR_HI, byte_v);
    chk(16'(byte_v), 16'h0000, "gain not readable");
  endtask

  // Writes the result bytes with gain access off; nothing may change.
  task automatic t_locked();
    gain_set(`ARFG_GADDR_HI, 8'h55);
    gain_set(`ARFG_GADDR_EXTRA, 8'h01);
    @(posedge ref_clk);
    #2;
    chk(16'(gain_word_high_q), 16'h006c, "gain high locked");
    chk(16'(gain_scaled_q), 16'h06ca, "gain locked");
    rd_res(res_a);
    chk(res_a, res_b, "result locked");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sample_valid = 1'b0;
    sample = 12'h000;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    t_reset();
    series(2'h0, 1, 1'b0, 12'hfff, 12'h000);
    series(2'h0, 1, 1'b1, 12'hfff, 12'h000);
    series(2'h0, 1, 1'b1, 12'h800, 12'h000);
    series(2'h1, 4, 1'b0, 12'hfff, 12'h000);
    series(2'h2, 8, 1'b0, 12'hfff, 12'h000);
    series(2'h3, 16, 1'b0, 12'hfff, 12'h000);
    series(2'h3, 16, 1'b0, 12'hfff, 12'h111);
    series(2'h1, 4, 1'b0, 12'h7ff, 12'h000);
    t_gain();
    t_locked();
    rd(8'h00, byte_v);
    chk(16'(byte_v), 16'h0000, "unmapped read");
    close_out();
  end

  // Cuts a hang short well beyond the expected run of about two hundred cycles.
  initial begin
    #400000;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
